// >>> rtl/encps_scaling.sv
`timescale 1ns/1ns
`default_nettype none
// How it works
// (RQ1) Byte 9 bit 0 chooses whether clockwise or counter-clockwise rotation counts upward.
// (RQ2) Class 2 behaviour only when byte 9 bit 1 is set, otherwise inactive.
// (RQ3) Byte 9 bit 3 enables the scaling parameters units and total range.
// (RQ4) Byte 26 is used only when byte 9 bit 6 is set.
// (RQ5) Desired units are 32 bits from bytes 10 to 13, byte 10 most significant.
// (RQ6) Units above physical base resolution raise parameter error and block data exchange.
// (RQ7) Total range is 32 bits from bytes 14 to 17, byte 14 most significant.
// (RQ8) Position counts to total range minus one, then wraps to zero, both directions; code wraps at total range only with per-revolution scaling.
// (RQ9) With per-revolution basis the total range sets the counting range.
// (RQ10) Byte 26 fields: basis, commissioning, short diagnostics, limit enables, extra bytes.
// (RQ11) Commissioning diagnostics bit of byte 9 has no effect.
// (RQ12) Total range must be below units times revolutions, else parameter error.
// (RQ13) Basis code: 00 per revolution, bit 0 per total range, bit 1 per impulse.
// (RQ14) Reserved bits of bytes 9, 26 and 39 are ignored and never raise errors.
module encps_scaling #(
  parameter logic [31:0] PHYS_STEPS = encps_pkg::ENCPS_PHYS_STEPS_DEF,
  parameter logic [31:0] PHYS_REVS = encps_pkg::ENCPS_PHYS_REVS_DEF
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic prm_wr,
  input wire logic [5:0] prm_index,
  input wire logic [7:0] prm_data,
  input wire logic prm_commit,
  input wire logic step_pin,
  input wire logic ccw_pin,
  output logic [31:0] position,
  output logic param_error_msg,
  output logic led_error,
  output logic data_exchange,
  output logic class2_active,
  output logic scaling_active,
  output logic [1:0] unit_basis,
  output logic commission_mode,
  output logic short_diag,
  output logic lower_limit_en,
  output logic upper_limit_en,
  output logic ext_bytes_en
);
  import encps_pkg::*;

  logic rst_m_reg, rst_s_reg, rst_int_n;
  logic step_m_reg, step_s_reg, step_d_reg, ccw_m_reg, ccw_s_reg;
  encps_state_t state_reg;
  logic [5:0] rd_addr_reg, rd_idx_reg;
  logic rd_pend_reg;
  logic [7:0] rd_data, flags_reg, mfr_reg;
  logic [31:0] units_reg, range_reg, imp_reg, base_reg, modulus_reg, frac_reg;
  logic [63:0] units_revs;
  logic [32:0] frac_up;
  logic step_ev, cnt_up, bump;
  logic scale_on;
  logic [1:0] basis;

  // Reset asserts at once, releases after two clean edges
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_m_reg <= 1'b0;
      rst_s_reg <= 1'b0;
    end else begin
      rst_m_reg <= 1'b1;
      rst_s_reg <= rst_m_reg;
    end
  end
  assign rst_int_n = rst_s_reg;

  // Shaft pulses arrive from the sensor pins, so resynchronise first
  always_ff @(posedge mclk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      step_m_reg <= 1'b0;
      step_s_reg <= 1'b0;
      step_d_reg <= 1'b0;
      ccw_m_reg <= 1'b0;
      ccw_s_reg <= 1'b0;
    end else if (clk_en) begin
      step_m_reg <= step_pin;
      step_s_reg <= step_m_reg;
      step_d_reg <= step_s_reg;
      ccw_m_reg <= ccw_pin;
      ccw_s_reg <= ccw_m_reg;
    end
  end
  assign step_ev = step_s_reg && !step_d_reg;
  // Bit clear ascends on clockwise (ccw low), bit set ascends on counter-clockwise
  assign cnt_up = (ccw_s_reg == flags_reg[ENCPS_F_DIR]); // see (RQ1)

  encps_prm_mem encps_prm_mem_i (
    .clk(mclk),
    .ce(clk_en),
    .wr_en(prm_wr),
    .wr_addr(prm_index),
    .wr_data(prm_data),
    .rd_addr(rd_addr_reg),
    .rd_data(rd_data)
  );

  // Class 2 gates scaling: class 1 use ignores units and range
  assign scale_on = flags_reg[ENCPS_F_CLASS2] && flags_reg[ENCPS_F_SCALE]; // see (RQ2) (RQ3)
  // Byte 9 bit 2 is never read here: no commissioning diagnostics see (RQ11)
  assign basis = mfr_reg[ENCPS_M_BASIS_HI:ENCPS_M_BASIS_LO]; // see (RQ13)
  // Full-width product: the default revolution count does not fit 12 bits
  assign units_revs = units_reg * PHYS_REVS;

  // Telegram sequencer: walk the stored bytes after the commit strobe
  always_ff @(posedge mclk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      state_reg <= ENCPS_IDLE;
      rd_addr_reg <= ENCPS_BYTE_FLAGS;
      rd_idx_reg <= ENCPS_BYTE_FLAGS;
      rd_pend_reg <= 1'b0;
    end else if (clk_en) begin
      case (state_reg)
        ENCPS_IDLE, ENCPS_RUN: begin
          if (prm_commit) begin
            state_reg <= ENCPS_LOAD;
            rd_addr_reg <= ENCPS_BYTE_FLAGS;
            rd_pend_reg <= 1'b0;
          end
        end
        ENCPS_LOAD: begin
          rd_pend_reg <= 1'b1;
          rd_idx_reg <= rd_addr_reg;
          if (rd_pend_reg && rd_idx_reg == ENCPS_BYTE_IMP_LO) begin
            state_reg <= ENCPS_CHECK;
          end else if (rd_addr_reg != ENCPS_BYTE_IMP_LO) begin
            rd_addr_reg <= rd_addr_reg + 6'h01;
          end
        end
        ENCPS_CHECK: begin
          state_reg <= ENCPS_RUN;
        end
        default: begin
          state_reg <= ENCPS_IDLE;
        end
      endcase
    end
  end

  // Byte capture; multi-byte words shift in most significant byte first
  always_ff @(posedge mclk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      flags_reg <= ENCPS_FLAGS_RST;
      mfr_reg <= ENCPS_MFR_RST;
      units_reg <= ENCPS_WORD_RST;
      range_reg <= ENCPS_WORD_RST;
      imp_reg <= ENCPS_WORD_RST;
    end else if (clk_en && state_reg == ENCPS_LOAD && rd_pend_reg) begin
      if (rd_idx_reg == ENCPS_BYTE_FLAGS) begin
        flags_reg <= rd_data;
      end else if (rd_idx_reg >= ENCPS_BYTE_UNITS_HI && rd_idx_reg <= ENCPS_BYTE_UNITS_LO) begin
        units_reg <= {units_reg[23:0], rd_data}; // see (RQ5)
      end else if (rd_idx_reg >= ENCPS_BYTE_RANGE_HI && rd_idx_reg <= ENCPS_BYTE_RANGE_LO) begin
        range_reg <= {range_reg[23:0], rd_data}; // see (RQ7)
      end else if (rd_idx_reg == ENCPS_BYTE_MFR) begin
        // Inactive byte 26 reads as all-zero settings see (RQ4)
        mfr_reg <= flags_reg[ENCPS_F_MFR] ? rd_data : ENCPS_MFR_RST;
      end else if (rd_idx_reg >= ENCPS_BYTE_IMP_HI && rd_idx_reg <= ENCPS_BYTE_IMP_LO) begin
        imp_reg <= {imp_reg[23:0], rd_data};
      end
    end
  end

  // Resolve scale base and wrap modulus, and check the parameter set
  always_ff @(posedge mclk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      base_reg <= PHYS_STEPS;
      modulus_reg <= ENCPS_WORD_RST;
      param_error_msg <= 1'b0;
      led_error <= 1'b0;
      data_exchange <= 1'b0;
    end else if (clk_en) begin
      if (state_reg == ENCPS_CHECK) begin
        // Reserved bits are never examined, so they cannot fail a check see (RQ14)
        if (!scale_on) begin
          base_reg <= PHYS_STEPS;
          modulus_reg <= 32'(PHYS_STEPS * PHYS_REVS);
          param_error_msg <= 1'b0;
        end else if (basis == ENCPS_BASIS_PER_REV) begin
          base_reg <= PHYS_STEPS;
          modulus_reg <= range_reg; // see (RQ9)
          param_error_msg <= (units_reg > PHYS_STEPS) || (units_reg == 32'h0) ||
                             ({32'h0000_0000, range_reg} >= units_revs) ||
                             (range_reg == 32'h0); // see (RQ6) (RQ12)
        end else if (basis == ENCPS_BASIS_PER_RANGE) begin
          // Ratio is units over all physical steps, so units above the base raise the error
          base_reg <= 32'(PHYS_STEPS * PHYS_REVS);
          modulus_reg <= units_reg;
          param_error_msg <= (units_reg > 32'(PHYS_STEPS * PHYS_REVS)) ||
                             (units_reg == 32'h0); // see (RQ6)
        end else begin
          base_reg <= imp_reg;
          modulus_reg <= 32'(units_reg * PHYS_REVS);
          param_error_msg <= (units_reg > imp_reg) || (units_reg == 32'h0); // see (RQ6)
        end
      end
      led_error <= param_error_msg; // see (RQ6)
      // Held out of data exchange while an error stands see (RQ6) (RQ12)
      data_exchange <= (state_reg == ENCPS_RUN) && !param_error_msg;
    end
  end

  // Fractional accumulator: units per base physical steps, no divider needed
  assign frac_up = {1'b0, frac_reg} + {1'b0, units_reg};
  always_comb begin
    bump = 1'b0;
    if (step_ev) begin
      if (!scale_on) begin
        bump = 1'b1;
      end else if (cnt_up) begin
        bump = frac_up >= {1'b0, base_reg};
      end else begin
        bump = frac_reg < units_reg;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      frac_reg <= ENCPS_WORD_RST;
      position <= ENCPS_WORD_RST;
    end else if (clk_en) begin
      if (state_reg != ENCPS_RUN) begin
        frac_reg <= ENCPS_WORD_RST;
        position <= ENCPS_WORD_RST;
      end else if (step_ev) begin
        if (scale_on && cnt_up) begin
          frac_reg <= bump ? 32'(frac_up - {1'b0, base_reg}) : frac_up[31:0];
        end else if (scale_on) begin
          frac_reg <= bump ? frac_reg + base_reg - units_reg : frac_reg - units_reg;
        end
        if (bump && cnt_up) begin
          position <= (position >= modulus_reg - 32'h1) ? 32'h0 : position + 32'h1; // see (RQ8)
        end else if (bump) begin
          position <= (position == 32'h0) ? modulus_reg - 32'h1 : position - 32'h1; // see (RQ8)
        end
      end
    end
  end

  // Decoded option outputs see (RQ10)
  always_ff @(posedge mclk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      class2_active <= 1'b0;
      scaling_active <= 1'b0;
      unit_basis <= ENCPS_BASIS_PER_REV;
      commission_mode <= 1'b0;
      short_diag <= 1'b0;
      lower_limit_en <= 1'b0;
      upper_limit_en <= 1'b0;
      ext_bytes_en <= 1'b0;
    end else if (clk_en) begin
      class2_active <= flags_reg[ENCPS_F_CLASS2]; // see (RQ2)
      scaling_active <= scale_on; // see (RQ3)
      unit_basis <= basis;
      commission_mode <= mfr_reg[ENCPS_M_COMMISSION];
      short_diag <= mfr_reg[ENCPS_M_SHORT_DIAG];
      lower_limit_en <= mfr_reg[ENCPS_M_LOW_LIM];
      upper_limit_en <= mfr_reg[ENCPS_M_UP_LIM];
      ext_bytes_en <= mfr_reg[ENCPS_M_EXT_BYTES];
    end
  end
endmodule
`default_nettype wire

// >>> shared/encps_pkg.sv
package encps_pkg;
  localparam int ENCPS_ADDR_W = 6;
  localparam int ENCPS_DEPTH = 40;
  localparam logic [5:0] ENCPS_BYTE_FLAGS = 6'h09;
  localparam logic [5:0] ENCPS_BYTE_UNITS_HI = 6'h0a;
  localparam logic [5:0] ENCPS_BYTE_UNITS_LO = 6'h0d;
  localparam logic [5:0] ENCPS_BYTE_RANGE_HI = 6'h0e;
  localparam logic [5:0] ENCPS_BYTE_RANGE_LO = 6'h11;
  localparam logic [5:0] ENCPS_BYTE_MFR = 6'h1a;
  localparam logic [5:0] ENCPS_BYTE_IMP_HI = 6'h23;
  localparam logic [5:0] ENCPS_BYTE_IMP_LO = 6'h26;
  localparam int ENCPS_F_DIR = 0;
  localparam int ENCPS_F_CLASS2 = 1;
  localparam int ENCPS_F_COMM_DIAG = 2;
  localparam int ENCPS_F_SCALE = 3;
  localparam int ENCPS_F_MFR = 6;
  localparam int ENCPS_M_BASIS_LO = 0;
  localparam int ENCPS_M_BASIS_HI = 1;
  localparam int ENCPS_M_COMMISSION = 2;
  localparam int ENCPS_M_SHORT_DIAG = 3;
  localparam int ENCPS_M_LOW_LIM = 5;
  localparam int ENCPS_M_UP_LIM = 6;
  localparam int ENCPS_M_EXT_BYTES = 7;
  localparam logic [1:0] ENCPS_BASIS_PER_REV = 2'h0;
  localparam logic [1:0] ENCPS_BASIS_PER_RANGE = 2'h1;
  localparam logic [1:0] ENCPS_BASIS_PER_IMP = 2'h2;
  localparam logic [7:0] ENCPS_FLAGS_RST = 8'h00;
  localparam logic [7:0] ENCPS_MFR_RST = 8'h00;
  localparam logic [31:0] ENCPS_WORD_RST = 32'h0000_0000;
  localparam logic [31:0] ENCPS_PHYS_STEPS_DEF = 32'h0000_2000;
  localparam logic [31:0] ENCPS_PHYS_REVS_DEF = 32'h0000_1000;
  typedef enum logic [3:0] {
    ENCPS_IDLE = 4'b0001,
    ENCPS_LOAD = 4'b0010,
    ENCPS_CHECK = 4'b0100,
    ENCPS_RUN = 4'b1000
  } encps_state_t;
endpackage

// >>> rtl/encps_prm_mem.sv
`timescale 1ns/1ns
`default_nettype none
module encps_prm_mem #(
  parameter int DEPTH = encps_pkg::ENCPS_DEPTH,
  parameter int AW = encps_pkg::ENCPS_ADDR_W
) (
  input wire logic clk,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (ce && wr_en && (int'(wr_addr) < DEPTH)) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Read data registered; out-of-range addresses read as zero
  always_ff @(posedge clk) begin
    if (ce) begin
      if (int'(rd_addr) < DEPTH) begin
        rd_data <= mem[rd_addr];
      end else begin
        rd_data <= 8'h00;
      end
    end
  end
endmodule
`default_nettype wire

// >>> test/encps_scaling_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module encps_scaling_monitor (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic prm_commit,
  input wire logic step_pin,
  input wire logic [31:0] position,
  input wire logic param_error_msg,
  input wire logic led_error,
  input wire logic data_exchange,
  input wire logic class2_active,
  input wire logic scaling_active
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_err_blocks;
    param_error_msg |-> !data_exchange;
  endproperty
  a_err_blocks: assert property (p_err_blocks) else $error("exchange in error");
  property p_led_rise;
    $rose(param_error_msg) |=> led_error ##1 !data_exchange;
  endproperty
  a_led_rise: assert property (p_led_rise) else $error("led missed error");
  property p_led_fall;
    $fell(param_error_msg) |=> !led_error;
  endproperty
  a_led_fall: assert property (p_led_fall) else $error("led stuck");
  property p_answer;
    $rose(prm_commit) |-> ##2 !data_exchange ##[28:40] (data_exchange || led_error);
  endproperty
  a_answer: assert property (p_answer) else $error("commit unanswered");
  property p_scale_class;
    scaling_active |-> class2_active;
  endproperty
  a_scale_class: assert property (p_scale_class) else $error("scaling w/o class2");
  property p_pos_step;
    data_exchange && $past(data_exchange) |-> position == $past(position)
      || position == $past(position) + 32'h1 || position == $past(position) - 32'h1
      || position == 32'h0 || $past(position) == 32'h0;
  endproperty
  a_pos_step: assert property (p_pos_step) else $error("position jump");
  // Step edge lands 2 to 3 cycles later, so six quiet cycles settle it
  property p_pos_still;
    (!step_pin && !prm_commit && data_exchange)[*6] ##1 data_exchange |-> $stable(position);
  endproperty
  a_pos_still: assert property (p_pos_still) else $error("position drift");
  property p_commit_zero;
    prm_commit |=> ##1 (position == 32'h0)[*4];
  endproperty
  a_commit_zero: assert property (p_commit_zero) else $error("position kept");
endmodule
`default_nettype wire

// >>> test/encps_master_model.sv
`timescale 1ns/1ns
`default_nettype none
module encps_master_model (
  input wire logic mclk,
  output logic prm_wr,
  output logic [5:0] prm_index,
  output logic [7:0] prm_data,
  output logic prm_commit,
  output logic step_pin,
  output logic ccw_pin
);
  initial begin
    prm_wr = 1'b0;
    prm_index = 6'h00;
    prm_data = 8'h00;
    prm_commit = 1'b0;
    step_pin = 1'b0;
    ccw_pin = 1'b0;
  end
  task automatic wr_byte(input logic [5:0] idx, input logic [7:0] d);
    @(negedge mclk);
    prm_wr = 1'b1;
    prm_index = idx;
    prm_data = d;
    @(negedge mclk);
    prm_wr = 1'b0;
    prm_data = ~d;
  endtask
  // Whole telegram always precedes the commit
  task automatic commit;
    @(negedge mclk);
    prm_commit = 1'b1;
    @(negedge mclk);
    prm_commit = 1'b0;
    repeat (45) @(negedge mclk);
  endtask
  task automatic step(input logic ccw);
    @(negedge mclk);
    ccw_pin = ccw;
    step_pin = 1'b1;
    repeat (3) @(negedge mclk);
    step_pin = 1'b0;
    repeat (3) @(negedge mclk);
  endtask
endmodule
`default_nettype wire

// >>> test/encps_scaling_bench.sv
`timescale 1ns/1ns
`default_nettype none
module encps_scaling_bench;
  import encps_pkg::*;
  localparam logic [31:0] PS = 32'h4;
  localparam logic [31:0] PR = 32'h8;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic prm_wr, prm_commit, step_pin, ccw_pin;
  logic [5:0] prm_index;
  logic [7:0] prm_data;
  logic [31:0] position;
  logic param_error_msg, led_error, data_exchange, class2_active, scaling_active;
  logic [1:0] unit_basis;
  logic commission_mode, short_diag, lower_limit_en, upper_limit_en, ext_bytes_en;
  logic [7:0] tel [9:38];
  int err_count = 0;
  int cmp_count = 0;
  always #4 mclk = ~mclk;
  encps_master_model mst (.mclk, .prm_wr, .prm_index, .prm_data, .prm_commit,
    .step_pin, .ccw_pin);
  encps_scaling #(.PHYS_STEPS(PS), .PHYS_REVS(PR)) encps_scaling_i (.mclk, .rst_n,
    .clk_en, .prm_wr, .prm_index, .prm_data, .prm_commit, .step_pin, .ccw_pin,
    .position, .param_error_msg, .led_error, .data_exchange, .class2_active,
    .scaling_active, .unit_basis, .commission_mode, .short_diag, .lower_limit_en,
    .upper_limit_en, .ext_bytes_en);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic run(input logic [7:0] b9, b26, input logic [31:0] u, r, p);
    for (int i = 9; i <= 38; i++) tel[i] = 8'h00;
    tel[ENCPS_BYTE_FLAGS] = b9;
    {tel[10], tel[11], tel[12], tel[13]} = u;
    {tel[14], tel[15], tel[16], tel[17]} = r;
    tel[ENCPS_BYTE_MFR] = b26;
    {tel[35], tel[36], tel[37], tel[38]} = p;
    for (int i = 9; i <= 38; i++) mst.wr_byte(6'(i), tel[i]);
    mst.commit();
  endtask
  task automatic steps(input int n, input logic ccw);
    repeat (n) mst.step(ccw);
    repeat (2) @(negedge mclk);
  endtask
  function automatic logic [31:0] opts();
    return 32'({unit_basis, commission_mode, short_diag, lower_limit_en,
      upper_limit_en, ext_bytes_en});
  endfunction
  function automatic logic [31:0] st();
    return 32'({class2_active, scaling_active, data_exchange, param_error_msg, led_error});
  endfunction
  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge mclk);
    rst_n = 1'b1;
    repeat (3) @(negedge mclk);
    run(8'h00, 8'h00, 32'h0, 32'h0, 32'h0);
    chk(st(), 32'h04);
    steps(3, 1'b0);
    chk(position, 32'h3);
    steps(4, 1'b1);
    chk(position, PS * PR - 32'h1);
    $display("test class1 done");
    // Every flag and reserved bit of bytes 9 and 26 set, per-revolution basis
    run(8'hff, 8'hfc, PS, 32'h8, 32'h0);
    chk(st(), 32'h1c);
    chk(opts(), 32'h1f);
    steps(9, 1'b1);
    chk(position, 32'h1);
    run(8'hbf, 8'hfc, PS, 32'h8, 32'h0);
    chk(opts(), 32'h0);
    $display("test options done");
    run(8'hff, 8'h00, PS + 32'h1, 32'h8, 32'h0);
    chk(st(), 32'h1b);
    run(8'hff, 8'h00, PS, PS * PR, 32'h0);
    chk(st(), 32'h1b);
    run(8'hff, 8'h00, PS, PS * PR - 32'h1, 32'h0);
    chk(st(), 32'h1c);
    $display("test errors done");
    run(8'h4b, 8'h01, PS * PR, 32'h8, 32'h0);
    chk(opts(), 32'h20);
    steps(1, 1'b0);
    chk(position, PS * PR - 32'h1);
    run(8'h4b, 8'h02, 32'h3, 32'h8, 32'h2);
    chk(st(), 32'h1b);
    chk(opts(), 32'h40);
    run(8'h4b, 8'h02, 32'h2, 32'h8, 32'h2);
    steps(1, 1'b0);
    chk(position, 32'h2 * PR - 32'h1);
    $display("test basis done");
    // A step that comes and goes while the enable is low must leave no trace
    clk_en = 1'b0;
    steps(1, 1'b0);
    clk_en = 1'b1;
    repeat (4) @(negedge mclk);
    chk(position, 32'h2 * PR - 32'h1);
    chk(st(), 32'h1c);
    $display("test enable done");
    conclude();
  end
endmodule
bind encps_scaling encps_scaling_monitor encps_scaling_monitor_i (.mclk, .rst_n,
  .prm_commit, .step_pin, .position, .param_error_msg, .led_error, .data_exchange,
  .class2_active, .scaling_active);
`default_nettype wire
